// ---- design/digital_output_router_defines.svh ----
`ifndef DIGITAL_OUTPUT_ROUTER_DEFINES_SVH
`define DIGITAL_OUTPUT_ROUTER_DEFINES_SVH

// ****************************************************************
// object addresses
// ****************************************************************
`define IDX_OUTPUT_CONTROL 16'h60FE
`define SUB_OUTPUT_CONTROL 8'h01
`define IDX_OUTPUT_CONFIG 16'h3250
`define SUB_POLARITY 8'h02
`define SUB_FORCE_ENABLE 8'h03
`define SUB_FORCE_VALUE 8'h04
`define SUB_APPLIED 8'h05
`define SUB_ROUTE_ENABLE 8'h08
`define SUB_LED_CONTROL 8'h09
`define IDX_ROUTE_TABLE 16'h3252
`define SUB_ROUTE_FIRST 8'h01
`define SUB_ROUTE_LAST 8'h05

// ****************************************************************
// field positions
// ****************************************************************
`define OUT_FIRST_BIT 16
`define BRAKE_BIT 0
`define ROUTE_SRC_MSB 15
`define ROUTE_SRC_LSB 8
`define ROUTE_INV_BIT 7
`define ROUTE_SEL_MSB 4
`define LED_GREEN_BIT 0
`define LED_RED_BIT 1

// ****************************************************************
// source codes
// ****************************************************************
`define SRC_ONE 8'h00
`define SRC_ZERO 8'h01
`define SRC_ENC_FIRST 8'h02
`define SRC_ENC_LAST 8'h08
`define SRC_POS_FIRST 8'h09
`define SRC_POS_LAST 8'h0F
`define SRC_PWM 8'h10
`define SRC_PWM_INV 8'h11

// ****************************************************************
// reset values
// ****************************************************************
`define RST_WORD 32'h0000_0000
`define RST_ROUTE 16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 10000000
`define SWPWM_MAX_HZ 2000
`define OUT_MAX_HZ 500
`define DIV_STAGES 7

`endif

// ---- design/digital_output_router_pkg.sv ----
package digital_output_router_pkg;
	typedef logic [31:0] word_t;
	typedef logic [15:0] route_entry_t;
	typedef logic [14:0] hold_count_t;
endpackage

// ---- design/pulse_train_divider.sv ----
`timescale 1ns/1ps
`include "digital_output_router_defines.svh"

module pulse_train_divider (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic step,
	output logic [`DIV_STAGES-1:0] div_pulse
);
	logic [`DIV_STAGES-2:0] count;
	logic [`DIV_STAGES-2:0] next_count;
	logic [`DIV_STAGES-1:0] next_div_pulse;

	// ****************************************************************
	// stage k fires once per 2**k steps
	// ****************************************************************
	always_comb begin
		next_count = count;
		next_div_pulse = '0;
		if (step) begin
			next_count = count + 6'h01;
			for (int k = 0; k < `DIV_STAGES; k++) begin
				next_div_pulse[k] = 1'b1;
				for (int j = 0; j < k; j++) begin
					if (!count[j])
						next_div_pulse[k] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			div_pulse <= '0;
		end else if (ce) begin
			count <= next_count;
			div_pulse <= next_div_pulse;
		end
	end
endmodule

// ---- design/digital_output_router.sv ----
// Summary of operation
// - output n follows control bit 15+n
// - low bits special; bit 0 commands brake
// - outputs open drain; external pull-up needed
// - polarity bit 1 inverts control bit
// - manual enable overrides control word, brake too
// - manual value drives each overridden output
// - applied bit pattern readable after processing
// - led control bits 0,1 enable green, red
// - routing ignores polarity and manual settings
// - routed source gated by selected control bit
// - entry high byte source, low byte bit
// - entry bit 7 inverts the gating sense
// - entry1 software pwm, entry2.. outputs 1..
// - source 00 constant one, 01 zero
// - sources 02-08 encoder pulses divided 1..64
// - sources 09-0F position pulses divided 1..64
// - one pulse per single count increment
// - source 10 brake pwm, 11 inverted
// - software pwm 2 kHz, others 500 Hz
`timescale 1ns/1ps
`include "digital_output_router_defines.svh"

module digital_output_router #(
	parameter int OUT_HOLD_CYCLES = `CLK_HZ / (2 * `OUT_MAX_HZ)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] obj_index,
	input wire logic [7:0] obj_sub,
	input wire logic obj_wr,
	input wire logic obj_rd,
	input wire logic [31:0] obj_wdata,
	output logic [31:0] obj_rdata,
	output logic obj_ack,
	output logic obj_err,
	input wire logic enc_step,
	input wire logic pos_step,
	input wire logic brake_pwm,
	input wire logic led_green_flash,
	input wire logic led_red_flash,
	output logic led_green,
	output logic led_red,
	output logic brake_out,
	input wire logic [3:0] dout_pin_in,
	output logic [3:0] dout_out,
	output logic [3:0] dout_oe,
	input wire logic swpwm_pin_in,
	output logic swpwm_out,
	output logic swpwm_oe
);
	localparam int NUM_OUT = 4;
	localparam int NUM_CH = NUM_OUT + 1;
	localparam int SW_HOLD_CYCLES = `CLK_HZ / (2 * `SWPWM_MAX_HZ);

	// ****************************************************************
	// object store
	// ****************************************************************
	digital_output_router_pkg::word_t ctrl, next_ctrl;
	digital_output_router_pkg::word_t polarity, next_polarity;
	digital_output_router_pkg::word_t force_en, next_force_en;
	digital_output_router_pkg::word_t force_val, next_force_val;
	digital_output_router_pkg::word_t applied, next_applied;
	digital_output_router_pkg::route_entry_t route [NUM_CH];
	digital_output_router_pkg::route_entry_t next_route [NUM_CH];
	logic route_on, next_route_on;
	logic [1:0] led_ctrl, next_led_ctrl;
	logic [31:0] next_rdata;
	logic next_ack, next_err;

	function automatic logic is_addr(input logic [15:0] idx,
		input logic [7:0] sub, input logic [15:0] want_idx,
		input logic [7:0] want_sub);
		is_addr = (idx == want_idx) && (sub == want_sub);
	endfunction

	function automatic logic is_route(input logic [15:0] idx,
		input logic [7:0] sub);
		is_route = (idx == `IDX_ROUTE_TABLE) &&
			(sub >= `SUB_ROUTE_FIRST) && (sub <= `SUB_ROUTE_LAST);
	endfunction

	always_comb begin
		next_ctrl = ctrl;
		next_polarity = polarity;
		next_force_en = force_en;
		next_force_val = force_val;
		next_route_on = route_on;
		next_led_ctrl = led_ctrl;
		next_route = route;
		next_rdata = obj_rdata;
		next_ack = 1'b0;
		next_err = 1'b0;
		if (obj_wr) begin
			next_ack = 1'b1;
			if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONTROL,
				`SUB_OUTPUT_CONTROL))
				next_ctrl = obj_wdata;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_POLARITY))
				next_polarity = obj_wdata;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_FORCE_ENABLE))
				next_force_en = obj_wdata;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_FORCE_VALUE))
				next_force_val = obj_wdata;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_ROUTE_ENABLE))
				next_route_on = obj_wdata[0];
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_LED_CONTROL))
				next_led_ctrl = obj_wdata[1:0];
			else if (is_route(obj_index, obj_sub))
				next_route[3'(obj_sub - `SUB_ROUTE_FIRST)] =
					obj_wdata[15:0];
			else
				next_err = 1'b1;
		end else if (obj_rd) begin
			next_ack = 1'b1;
			next_rdata = '0;
			if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONTROL,
				`SUB_OUTPUT_CONTROL))
				next_rdata = ctrl;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_POLARITY))
				next_rdata = polarity;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_FORCE_ENABLE))
				next_rdata = force_en;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_FORCE_VALUE))
				next_rdata = force_val;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_APPLIED))
				next_rdata = applied;
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_ROUTE_ENABLE))
				next_rdata = {31'h0000_0000, route_on};
			else if (is_addr(obj_index, obj_sub, `IDX_OUTPUT_CONFIG,
				`SUB_LED_CONTROL))
				next_rdata = {30'h0000_0000, led_ctrl};
			else if (is_route(obj_index, obj_sub))
				next_rdata = {16'h0000,
					route[3'(obj_sub - `SUB_ROUTE_FIRST)]};
			else
				next_err = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= `RST_WORD;
			polarity <= `RST_WORD;
			force_en <= `RST_WORD;
			force_val <= `RST_WORD;
			route_on <= 1'b0;
			led_ctrl <= 2'h0;
			for (int i = 0; i < NUM_CH; i++)
				route[i] <= `RST_ROUTE;
			obj_rdata <= 32'h0000_0000;
			obj_ack <= 1'b0;
			obj_err <= 1'b0;
		end else if (ce) begin
			ctrl <= next_ctrl;
			polarity <= next_polarity;
			force_en <= next_force_en;
			force_val <= next_force_val;
			route_on <= next_route_on;
			led_ctrl <= next_led_ctrl;
			route <= next_route;
			obj_rdata <= next_rdata;
			obj_ack <= next_ack;
			obj_err <= next_err;
		end
	end

	// ****************************************************************
	// pulse trains
	// ****************************************************************
	logic [`DIV_STAGES-1:0] enc_div;
	logic [`DIV_STAGES-1:0] pos_div;

	pulse_train_divider enc_divider (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.step(enc_step),
		.div_pulse(enc_div)
	);

	pulse_train_divider pos_divider (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.step(pos_step),
		.div_pulse(pos_div)
	);

	// ****************************************************************
	// per-channel rate limiter
	// ****************************************************************
	// a pulse owns a full high+low period; pulses arriving meanwhile
	// are dropped, trading count accuracy for a bounded pin rate
	digital_output_router_pkg::hold_count_t hold [NUM_CH];
	digital_output_router_pkg::hold_count_t next_hold [NUM_CH];
	logic [NUM_CH-1:0] pulse_evt;
	logic [NUM_CH-1:0] pulse_lvl;

	function automatic logic pick_pulse(input logic [7:0] code,
		input logic [`DIV_STAGES-1:0] enc,
		input logic [`DIV_STAGES-1:0] pos);
		pick_pulse = 1'b0;
		if (code >= `SRC_ENC_FIRST && code <= `SRC_ENC_LAST)
			pick_pulse = enc[3'(code - `SRC_ENC_FIRST)];
		else if (code >= `SRC_POS_FIRST && code <= `SRC_POS_LAST)
			pick_pulse = pos[3'(code - `SRC_POS_FIRST)];
	endfunction

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			int half;
			half = (c == 0) ? SW_HOLD_CYCLES : OUT_HOLD_CYCLES;
			pulse_evt[c] = pick_pulse(
				route[c][`ROUTE_SRC_MSB:`ROUTE_SRC_LSB], enc_div, pos_div);
			pulse_lvl[c] = (int'(hold[c]) > half);
			next_hold[c] = hold[c];
			if (hold[c] != '0)
				next_hold[c] = hold[c] - 15'h0001;
			else if (pulse_evt[c])
				next_hold[c] = 15'(2 * half);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < NUM_CH; c++)
				hold[c] <= '0;
		end else if (ce) begin
			hold <= next_hold;
		end
	end

	// ****************************************************************
	// output forming
	// ****************************************************************
	// channel 0 is the software pwm pin, channel n is output n
	logic [NUM_CH-1:0] lvl;
	logic brake_lvl;

	function automatic logic manual_level(input int b,
		input logic [31:0] c, input logic [31:0] p,
		input logic [31:0] fe, input logic [31:0] fv);
		if (fe[b])
			manual_level = fv[b];
		else
			manual_level = c[b] ^ p[b];
	endfunction

	always_comb begin
		logic [7:0] src;
		logic gate;
		src = 8'h00;
		gate = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			src = route[c][`ROUTE_SRC_MSB:`ROUTE_SRC_LSB];
			gate = ctrl[route[c][`ROUTE_SEL_MSB:0]] ^
				route[c][`ROUTE_INV_BIT];
			if (route_on) begin
				lvl[c] = 1'b1;
				if (gate) begin
					if (src == `SRC_ONE)
						lvl[c] = 1'b1;
					else if (src == `SRC_ZERO)
						lvl[c] = 1'b0;
					else if (src == `SRC_PWM)
						lvl[c] = brake_pwm;
					else if (src == `SRC_PWM_INV)
						lvl[c] = ~brake_pwm;
					else if (src >= `SRC_ENC_FIRST && src <= `SRC_POS_LAST)
						lvl[c] = pulse_lvl[c];
				end
			end else if (c == 0) begin
				lvl[c] = 1'b1;
			end else begin
				lvl[c] = manual_level(`OUT_FIRST_BIT + c - 1, ctrl,
					polarity, force_en, force_val);
			end
		end
		if (route_on)
			brake_lvl = ctrl[`BRAKE_BIT];
		else
			brake_lvl = manual_level(`BRAKE_BIT, ctrl, polarity,
				force_en, force_val);
	end

	logic swpwm_lvl, next_swpwm_lvl;

	always_comb begin
		next_applied = '0;
		next_applied[`BRAKE_BIT] = brake_lvl;
		for (int i = 0; i < NUM_OUT; i++)
			next_applied[`OUT_FIRST_BIT + i] = lvl[i + 1];
		next_swpwm_lvl = lvl[0];
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			applied <= `RST_WORD;
			swpwm_lvl <= 1'b1;
		end else if (ce) begin
			applied <= next_applied;
			swpwm_lvl <= next_swpwm_lvl;
		end
	end

	// ****************************************************************
	// pins
	// ****************************************************************
	// a high level is only the external pull-up, so the driver pulls
	// low or lets go; pin read-back inputs are not used here
	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			dout_out[i] = 1'b0;
			dout_oe[i] = ~applied[`OUT_FIRST_BIT + i];
		end
		swpwm_out = 1'b0;
		swpwm_oe = ~swpwm_lvl;
		brake_out = applied[`BRAKE_BIT];
		led_green = led_ctrl[`LED_GREEN_BIT] & led_green_flash;
		led_red = led_ctrl[`LED_RED_BIT] & led_red_flash;
	end
endmodule

// ---- verification/digital_output_router_asserts.sv ----
`timescale 1ns/1ps
`include "digital_output_router_defines.svh"
// ****
// port checker
// ****
module digital_output_router_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] obj_index,
	input wire logic [7:0] obj_sub,
	input wire logic obj_wr,
	input wire logic obj_rd,
	input wire logic [31:0] obj_rdata,
	input wire logic obj_ack,
	input wire logic obj_err,
	input wire logic led_green_flash,
	input wire logic led_red_flash,
	input wire logic led_green,
	input wire logic led_red,
	input wire logic brake_out,
	input wire logic [3:0] dout_out,
	input wire logic swpwm_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_req; ce && (obj_wr || obj_rd); endsequence
	sequence s_ro_wr;
		ce && obj_wr && obj_index == `IDX_OUTPUT_CONFIG
		&& obj_sub == `SUB_APPLIED;
	endsequence
	sequence s_bad_sub;
		ce && (obj_wr || obj_rd) && obj_index == `IDX_ROUTE_TABLE
		&& obj_sub > `SUB_ROUTE_LAST;
	endsequence
	sequence s_refuse; obj_ack && obj_err; endsequence
	property p_ack; s_req |=> obj_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_idle; ce && !obj_wr && !obj_rd |=> !obj_ack; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_err; obj_err |-> obj_ack; endproperty
	a_err: assert property (p_err) else $error("err alone");
	property p_ro; s_ro_wr |=> s_refuse; endproperty
	a_ro: assert property (p_ro) else $error("ro write taken");
	property p_map; s_bad_sub |=> s_refuse; endproperty
	a_map: assert property (p_map) else $error("bad entry taken");
	property p_rdata; $changed(obj_rdata) |-> obj_ack; endproperty
	a_rdata: assert property (p_rdata) else $error("rdata moved");
	property p_od; dout_out == 4'h0 && !swpwm_out; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_grn; led_green |-> led_green_flash; endproperty
	a_grn: assert property (p_grn) else $error("green lit");
	property p_red; !led_red_flash |-> !led_red; endproperty
	a_red: assert property (p_red) else $error("red lit");
	// brake only follows object writes, a few cycles of pipe allowed
	property p_brk;
		$changed(brake_out) |->
		$past(obj_wr) || $past(obj_wr, 2) || $past(obj_wr, 3);
	endproperty
	a_brk: assert property (p_brk) else $error("brake moved");
endmodule
bind digital_output_router digital_output_router_asserts
	i_digital_output_router_asserts (.*);

// ---- verification/open_drain_load.sv ----
`timescale 1ns/1ps
// ****
// pulled-up field loads
// ****
module open_drain_load (
	input wire logic [3:0] dout_out,
	input wire logic [3:0] dout_oe,
	input wire logic swpwm_out,
	input wire logic swpwm_oe,
	output logic [3:0] pin,
	output logic swpwm_pin
);
	// released pins sit at the pull-up level, never a held value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i] = dout_oe[i] ? dout_out[i] : 1'h1;
		end
		swpwm_pin = swpwm_oe ? swpwm_out : 1'h1;
	end
endmodule

// ---- verification/digital_output_router_tb.sv ----
`timescale 1ns/1ps
`include "digital_output_router_defines.svh"
module digital_output_router_tb;
	logic ref_clk, rst, ce, obj_wr, obj_rd, obj_ack, obj_err;
	logic enc_step, pos_step, brake_pwm, led_green_flash, led_red_flash;
	logic led_green, led_red, brake_out, swpwm_pin, swpwm_out, swpwm_oe;
	logic [15:0] obj_index;
	logic [7:0] obj_sub;
	logic [31:0] obj_wdata, obj_rdata;
	logic [3:0] pin, pin_q, dout_out, dout_oe;
	int num_errors, samples_checked, rise0, rise1;
	// ****
	// block and loads
	// ****
	digital_output_router #(.OUT_HOLD_CYCLES(20))
	i_digital_output_router (
		.ref_clk, .rst, .ce, .obj_index, .obj_sub, .obj_wr, .obj_rd,
		.obj_wdata, .obj_rdata, .obj_ack, .obj_err, .enc_step, .pos_step,
		.brake_pwm, .led_green_flash, .led_red_flash, .led_green, .led_red,
		.brake_out, .dout_pin_in(pin), .dout_out, .dout_oe,
		.swpwm_pin_in(swpwm_pin), .swpwm_out, .swpwm_oe
	);
	open_drain_load i_open_drain_load (
		.dout_out, .dout_oe, .swpwm_out, .swpwm_oe, .pin, .swpwm_pin
	);
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		pin_q <= pin;
		if (pin[0] && !pin_q[0]) rise0++;
		if (pin[1] && !pin_q[1]) rise1++;
	end
	// ****
	// helpers
	// ****
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(string w, logic [31:0] x, logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", w, x, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic acc(logic w, logic [15:0] i, logic [7:0] s,
		logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		obj_index = i;
		obj_sub = s;
		obj_wdata = d;
		obj_wr = w;
		obj_rd = !w;
		cyc(1);
		obj_wr = 1'h0;
		obj_rd = 1'h0;
		for (n = 0; n < 4 && obj_ack !== 1'h1; n++) cyc(1);
		if (n == 4) begin
			num_errors++;
			close_out();
		end
		q = obj_rdata;
		e = obj_err;
		// gap cycle keeps the request strobes single-cycle
		cyc(1);
	endtask
	task automatic wr(logic [15:0] i, logic [7:0] s, logic [31:0] d);
		logic [31:0] q;
		logic e;
		acc(1'h1, i, s, d, q, e);
		chk("wr_err", 32'h0, {31'h0, e});
	endtask
	task automatic rd(logic [15:0] i, logic [7:0] s, logic [31:0] x);
		logic [31:0] q;
		logic e;
		acc(1'h0, i, s, 32'h0, q, e);
		chk("rd_data", x, q);
	endtask
	task automatic bad(logic w, logic [15:0] i, logic [7:0] s);
		logic [31:0] q;
		logic e;
		acc(w, i, s, 32'hF, q, e);
		chk("refuse", 32'h1, {31'h0, e});
	endtask
	task automatic pins(logic [4:0] x);
		chk("pins", {27'h0, x}, {27'h0, swpwm_pin, pin});
	endtask
	task automatic step(int gap);
		enc_step = 1'h1;
		pos_step = 1'h1;
		cyc(1);
		enc_step = 1'h0;
		pos_step = 1'h0;
		cyc(gap);
	endtask
	// ****
	// scenarios
	// ****
	task automatic s_reset;
		logic [7:0] subs [6];
		subs = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09};
		rd(`IDX_OUTPUT_CONTROL, `SUB_OUTPUT_CONTROL, 32'h0);
		foreach (subs[k]) rd(`IDX_OUTPUT_CONFIG, subs[k], 32'h0);
		for (int k = 1; k < 6; k++) rd(`IDX_ROUTE_TABLE, 8'(k), 32'h0);
		pins(5'h10);
		bad(1'h1, `IDX_OUTPUT_CONFIG, `SUB_APPLIED);
		bad(1'h0, `IDX_ROUTE_TABLE, 8'h06);
		rd(`IDX_OUTPUT_CONFIG, `SUB_APPLIED, 32'h0);
	endtask
	task automatic s_normal;
		wr(`IDX_OUTPUT_CONTROL, `SUB_OUTPUT_CONTROL, 32'h0005_0021);
		wr(`IDX_OUTPUT_CONFIG, `SUB_POLARITY, 32'h0003_0000);
		cyc(2);
		pins(5'h16);
		rd(`IDX_OUTPUT_CONFIG, `SUB_APPLIED, 32'h0006_0001);
		chk("brake", 32'h1, {31'h0, brake_out});
	endtask
	task automatic s_manual;
		wr(`IDX_OUTPUT_CONFIG, `SUB_FORCE_ENABLE, 32'h0003_0001);
		wr(`IDX_OUTPUT_CONFIG, `SUB_FORCE_VALUE, 32'h0001_0000);
		cyc(2);
		pins(5'h15);
		rd(`IDX_OUTPUT_CONFIG, `SUB_APPLIED, 32'h0005_0000);
		chk("brake", 32'h0, {31'h0, brake_out});
	endtask
	task automatic s_led;
		led_green_flash = 1'h1;
		led_red_flash = 1'h1;
		wr(`IDX_OUTPUT_CONFIG, `SUB_LED_CONTROL, 32'h1);
		chk("led", 32'h2, {30'h0, led_green, led_red});
		wr(`IDX_OUTPUT_CONFIG, `SUB_LED_CONTROL, 32'h2);
		chk("led", 32'h1, {30'h0, led_green, led_red});
		led_red_flash = 1'h0;
		cyc(1);
		chk("led", 32'h0, {30'h0, led_green, led_red});
	endtask
	task automatic s_route;
		wr(`IDX_ROUTE_TABLE, 8'h01, 32'h0105);
		wr(`IDX_ROUTE_TABLE, 8'h02, 32'h0005);
		wr(`IDX_ROUTE_TABLE, 8'h03, 32'h0106);
		wr(`IDX_ROUTE_TABLE, 8'h04, 32'hFFFF_0184);
		wr(`IDX_ROUTE_TABLE, 8'h05, 32'h0085);
		wr(`IDX_OUTPUT_CONTROL, `SUB_OUTPUT_CONTROL, 32'h21);
		wr(`IDX_OUTPUT_CONFIG, `SUB_ROUTE_ENABLE, 32'h1);
		cyc(2);
		pins(5'h0B);
		rd(`IDX_OUTPUT_CONFIG, `SUB_APPLIED, 32'h000B_0001);
		rd(`IDX_ROUTE_TABLE, 8'h04, 32'h0184);
	endtask
	task automatic s_pwm;
		logic [1:0] want [4];
		// inverted gate with control bit 0 set lets the pin go high
		want = '{2'h1, 2'h2, 2'h3, 2'h2};
		wr(`IDX_ROUTE_TABLE, 8'h02, 32'h1000);
		wr(`IDX_ROUTE_TABLE, 8'h03, 32'h1100);
		for (int k = 0; k < 4; k++) begin
			if (k == 2) wr(`IDX_ROUTE_TABLE, 8'h03, 32'h1180);
			brake_pwm = !k[0];
			cyc(3);
			chk("pwm", {30'h0, want[k]}, {30'h0, pin[1:0]});
		end
		brake_pwm = 1'h0;
	endtask
	task automatic s_hold;
		// enable low must freeze the applied word and so the pins
		ce = 1'h0;
		brake_pwm = 1'h1;
		cyc(3);
		chk("frozen", 32'h2, {30'h0, pin[1:0]});
		ce = 1'h1;
		cyc(3);
		chk("thawed", 32'h3, {30'h0, pin[1:0]});
		brake_pwm = 1'h0;
		cyc(3);
	endtask
	task automatic s_div;
		// 64 steps per code keeps every divider phase aligned at zero
		for (int k = 0; k < 7; k++) begin
			wr(`IDX_ROUTE_TABLE, 8'h02, {16'h0, 8'(2 + k), 8'h05});
			wr(`IDX_ROUTE_TABLE, 8'h03, {16'h0, 8'(9 + k), 8'h05});
			cyc(50);
			rise0 = 0;
			rise1 = 0;
			repeat (64) step(50);
			chk("enc_div", 64 >> k, rise0);
			chk("pos_div", 64 >> k, rise1);
		end
		wr(`IDX_ROUTE_TABLE, 8'h03, 32'h0905);
		cyc(50);
		rise1 = 0;
		repeat (3) step(3);
		cyc(50);
		chk("limit", 32'h1, rise1);
	endtask
	initial begin
		rst = 1'h1;
		ce = 1'h1;
		obj_index = 16'h0;
		obj_sub = 8'h0;
		obj_wr = 1'h0;
		obj_rd = 1'h0;
		obj_wdata = 32'h0;
		enc_step = 1'h0;
		pos_step = 1'h0;
		brake_pwm = 1'h0;
		led_green_flash = 1'h0;
		led_red_flash = 1'h0;
		num_errors = 0;
		samples_checked = 0;
		cyc(5);
		rst = 1'h0;
		cyc(1);
		s_reset();
		s_normal();
		s_manual();
		s_led();
		s_route();
		s_pwm();
		s_hold();
		s_div();
		close_out();
	end
endmodule
